// >>> sdc_pkg.sv
package sdc_pkg;

    typedef logic [15:0] sdc_word_t;
    typedef logic [6:0]  sdc_addr_t;

    // Serial frame: read flag, 7-bit address, 16-bit data, MSB first
    localparam logic [4:0] SDC_HEAD_LAST  = 5'h07;
    localparam logic [4:0] SDC_DATA_LAST  = 5'h0f;

    localparam int SDC_NUM_REGS = 16;

    localparam sdc_addr_t SDC_A_RSV_A     = 7'h19;
    localparam sdc_addr_t SDC_A_RSV_B     = 7'h1c;
    localparam sdc_addr_t SDC_A_RSV_C     = 7'h1d;
    localparam sdc_addr_t SDC_A_DBL_DITH  = 7'h1e;
    localparam sdc_addr_t SDC_A_DIST_PWR  = 7'h1f;
    localparam sdc_addr_t SDC_A_RSV_D     = 7'h20;
    localparam sdc_addr_t SDC_A_RSV_E     = 7'h21;
    localparam sdc_addr_t SDC_A_CHAN_DIVIDER_ON  = 7'h22;
    localparam sdc_addr_t SDC_A_SEG_CTRL  = 7'h23;
    localparam sdc_addr_t SDC_A_DIV_OUT   = 7'h24;
    localparam sdc_addr_t SDC_A_PRESCALE  = 7'h25;
    localparam sdc_addr_t SDC_A_INTEGER   = 7'h26;
    localparam sdc_addr_t SDC_A_PD_DELAY  = 7'h27;
    localparam sdc_addr_t SDC_A_DEN_HIGH  = 7'h28;
    localparam sdc_addr_t SDC_A_DEN_LOW   = 7'h29;
    localparam sdc_addr_t SDC_A_MOD_ORDER = 7'h2e;

    localparam int SDC_I_DBL_DITH  = 3;
    localparam int SDC_I_DIST_PWR  = 4;
    localparam int SDC_I_CHAN_DIVIDER_ON  = 7;
    localparam int SDC_I_SEG_CTRL  = 8;
    localparam int SDC_I_DIV_OUT   = 9;
    localparam int SDC_I_PRESCALE  = 10;
    localparam int SDC_I_INTEGER   = 11;
    localparam int SDC_I_PD_DELAY  = 12;
    localparam int SDC_I_DEN_HIGH  = 13;
    localparam int SDC_I_DEN_LOW   = 14;
    localparam int SDC_I_MOD_ORDER = 15;

    localparam sdc_addr_t SDC_REG_ADDR [SDC_NUM_REGS] = '{
        SDC_A_RSV_A, SDC_A_RSV_B, SDC_A_RSV_C, SDC_A_DBL_DITH,
        SDC_A_DIST_PWR, SDC_A_RSV_D, SDC_A_RSV_E, SDC_A_CHAN_DIVIDER_ON,
        SDC_A_SEG_CTRL, SDC_A_DIV_OUT, SDC_A_PRESCALE, SDC_A_INTEGER,
        SDC_A_PD_DELAY, SDC_A_DEN_HIGH, SDC_A_DEN_LOW, SDC_A_MOD_ORDER};

    // Reset values; bits without a documented default reset to zero
    localparam sdc_word_t SDC_RST_RSV      = 16'h0000;
    localparam sdc_word_t SDC_RST_DBL_DITH = 16'h0000;
    localparam sdc_word_t SDC_RST_DIST_PWR = 16'h0400;
    localparam sdc_word_t SDC_RST_CHAN_DIVIDER_ON = 16'h0020;
    localparam sdc_word_t SDC_RST_SEG_CTRL = 16'h0204;
    localparam sdc_word_t SDC_RST_DIV_OUT  = 16'h0411;
    localparam sdc_word_t SDC_RST_PRESCALE = 16'h0000;
    localparam sdc_word_t SDC_RST_INTEGER  = 16'h0036;
    localparam sdc_word_t SDC_RST_PD_DELAY = 16'h0200;
    localparam sdc_word_t SDC_RST_DEN      = 16'h03e8;
    localparam sdc_word_t SDC_RST_MOD_ORD  = 16'h0f83;

    localparam sdc_word_t SDC_REG_RST [SDC_NUM_REGS] = '{
        SDC_RST_RSV, SDC_RST_RSV, SDC_RST_RSV, SDC_RST_DBL_DITH,
        SDC_RST_DIST_PWR, SDC_RST_RSV, SDC_RST_RSV, SDC_RST_CHAN_DIVIDER_ON,
        SDC_RST_SEG_CTRL, SDC_RST_DIV_OUT, SDC_RST_PRESCALE, SDC_RST_INTEGER,
        SDC_RST_PD_DELAY, SDC_RST_DEN, SDC_RST_DEN, SDC_RST_MOD_ORD};

    localparam int SDC_B_DOUBLER     = 0;
    localparam int SDC_B_DITHER      = 10;
    localparam int SDC_B_OUTB_OFF    = 10;
    localparam int SDC_B_OUTA_OFF    = 9;
    localparam int SDC_B_FEED_OFF    = 7;
    localparam int SDC_B_CHDIV_ON    = 5;
    localparam int SDC_F_SEG2_LSB    = 9;
    localparam int SDC_B_SEG3_ON     = 8;
    localparam int SDC_B_SEG2_ON     = 7;
    localparam int SDC_B_SEG1_RATIO  = 2;
    localparam int SDC_B_SEG1_ON     = 1;
    localparam int SDC_B_DIV_OUTB_ON = 11;
    localparam int SDC_B_DIV_OUTA_ON = 10;
    localparam int SDC_F_CHAIN_LSB   = 4;
    localparam int SDC_F_SEG3_LSB    = 0;
    localparam int SDC_B_PRESCALE    = 12;
    localparam int SDC_F_INT_LSB     = 1;
    localparam int SDC_F_PDD_LSB     = 8;
    localparam int SDC_F_ORDER_LSB   = 0;

    typedef enum logic [1:0] {
        SDC_IDLE = 2'b00,
        SDC_HEAD = 2'b01,
        SDC_BODY = 2'b10,
        SDC_DONE = 2'b11
    } sdc_state_t;

endpackage : sdc_pkg

// >>> sdc_config_regs.sv
// Contract
// - Doubler/dither bit 0 enables the oscillator doubler; resets to zero.
// - Doubler/dither bit 10 turns modulator dithering on; resets to zero.
// - Distribution bit 10 powers down oscillator-to-output-B buffer; resets to one.
// - Distribution bit 9 powers down oscillator-to-output-A buffer; resets to zero.
// - Distribution bit 7 powers down the divider feed buffer; resets to zero.
// - Enable register bit 5 turns whole channel divider on; resets to one.
// - Second segment ratio bits 12:9 one-hot decode to 8,6,4,2 or off.
// - Segment enable bits 8, 7, 1 switch segments three, two, one; reset zero.
// - Segment bit 2 makes first segment divide by three, else two; resets one.
// - Output register bit 11 enables divider-to-output-B buffer; resets to zero.
// - Output register bit 10 enables divider-to-output-A buffer; resets to one.
// - Chain select bits 6:4: 4 three segments, 2 two, 1 one, 0 off.
// - Third segment ratio bits 3:0 decode like the second; resets to one.
// - Prescaler bit 12 selects divide by four, else two; resets to zero.
// - Integer register bits 12:1 hold feedback integer value; resets to 27.
// - Delay bits 13:8 decode 1,2,4,8,16 to 4,6,8,12,16 cycles; reset 2.
// - Denominator-high register holds denominator bits 31:16; resets to 1000.
// - Denominator-low register holds bits 15:0; resets to 1000.
// - Modulator order 4..1 fractional, 0 integer; dither only when fractional.
module sdc_config_regs (
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire logic                 ser_csb_n,
    input  wire logic                 ser_sck,
    input  wire logic                 ser_sdi,
    output logic                      ser_sdo,
    output logic                      ser_sdo_oe,
    output logic                      osc_doubler_enable,
    output logic                      modulator_dither,
    output logic                      modulator_dither_active,
    output logic                      osc_to_outb_buffer_off,
    output logic                      osc_to_outa_buffer_off,
    output logic                      divider_feed_buffer_off,
    output logic                      chan_divider_on,
    output logic                      first_segment_on,
    output logic                      second_segment_on,
    output logic                      third_segment_on,
    output logic                      first_segment_ratio,
    output logic [3:0]                second_segment_ratio,
    output logic [3:0]                third_segment_ratio,
    output logic [1:0]                first_segment_divide,
    output logic [3:0]                second_segment_divide,
    output logic [3:0]                third_segment_divide,
    output logic [2:0]                segment_chain_select,
    output logic [1:0]                segments_in_chain,
    output logic                      divider_to_outb_buffer_on,
    output logic                      divider_to_outa_buffer_on,
    output logic                      prescaler_by_four,
    output logic [2:0]                prescaler_divide,
    output logic [11:0]               feedback_integer_value,
    output logic [5:0]                phase_detector_delay_sel,
    output logic [4:0]                phase_detector_delay_cycles,
    output logic [31:0]               fraction_denominator,
    output logic [2:0]                modulator_order,
    output logic                      fractional_mode,
    output sdc_pkg::sdc_word_t        reserved_cfg_a,
    output sdc_pkg::sdc_word_t        reserved_cfg_b,
    output sdc_pkg::sdc_word_t        reserved_cfg_c,
    output sdc_pkg::sdc_word_t        reserved_cfg_d,
    output sdc_pkg::sdc_word_t        reserved_cfg_e
);
    import sdc_pkg::*;

    sdc_word_t  regs [SDC_NUM_REGS];

    logic       csb_meta;
    logic       csb_sync;
    logic       sck_meta;
    logic       sck_sync;
    logic       sck_prev;
    logic       sdi_meta;
    logic       sdi_sync;
    logic       sck_rise;
    logic       sck_fall;

    sdc_state_t state;
    logic [4:0] bit_cnt;
    logic [7:0] head_shift;
    sdc_word_t  data_shift;
    sdc_word_t  out_shift;
    logic [7:0] next_head;
    sdc_word_t  next_data;
    logic       frame_read;
    sdc_addr_t  frame_addr;
    logic       commit;

    logic [SDC_NUM_REGS-1:0] head_hit;
    logic [SDC_NUM_REGS-1:0] frame_hit;
    sdc_word_t               head_rdata;

    // Pins come from the host's domain; two stages before any use.
    // Host must hold each clock phase for at least three system clocks.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            csb_meta <= 1'b1;
            csb_sync <= 1'b1;
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_prev <= 1'b0;
            sdi_meta <= 1'b0;
            sdi_sync <= 1'b0;
        end else begin
            csb_meta <= ser_csb_n;
            csb_sync <= csb_meta;
            sck_meta <= ser_sck;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
            sdi_meta <= ser_sdi;
            sdi_sync <= sdi_meta;
        end
    end

    assign sck_rise  = sck_sync & ~sck_prev;
    assign sck_fall  = ~sck_sync & sck_prev;
    assign next_head = {head_shift[6:0], sdi_sync};
    assign next_data = {data_shift[14:0], sdi_sync};

    for (genvar i = 0; i < SDC_NUM_REGS; i++) begin : g_hit
        assign head_hit[i]  = (next_head[6:0] == SDC_REG_ADDR[i]);
        assign frame_hit[i] = (frame_addr == SDC_REG_ADDR[i]);
    end

    // Unmapped addresses read back as zero
    always_comb begin
        head_rdata = '0;
        for (int i = 0; i < SDC_NUM_REGS; i++) begin
            if (head_hit[i]) begin
                head_rdata = head_rdata | regs[i];
            end
        end
    end

    assign commit = (state == SDC_BODY) && sck_rise && (bit_cnt == SDC_DATA_LAST)
                    && !frame_read && !csb_sync;

    // Frame sequencer; a frame cut short by select rising is dropped whole
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= SDC_IDLE;
            bit_cnt    <= 5'h00;
            head_shift <= 8'h00;
            data_shift <= 16'h0000;
            frame_read <= 1'b0;
            frame_addr <= 7'h00;
        end else if (csb_sync) begin
            state   <= SDC_IDLE;
            bit_cnt <= 5'h00;
        end else begin
            case (state)
                SDC_IDLE: begin
                    state   <= SDC_HEAD;
                    bit_cnt <= 5'h00;
                    if (sck_rise) begin
                        head_shift <= next_head;
                        bit_cnt    <= 5'h01;
                    end
                end
                SDC_HEAD: begin
                    if (sck_rise) begin
                        head_shift <= next_head;
                        if (bit_cnt == SDC_HEAD_LAST) begin
                            state      <= SDC_BODY;
                            bit_cnt    <= 5'h00;
                            frame_read <= next_head[7];
                            frame_addr <= next_head[6:0];
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                SDC_BODY: begin
                    if (sck_rise) begin
                        data_shift <= next_data;
                        if (bit_cnt == SDC_DATA_LAST) begin
                            state <= SDC_DONE;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                SDC_DONE: begin
                    state <= SDC_DONE;
                end
                default: begin
                    state <= SDC_IDLE;
                end
            endcase
        end
    end

    // Readback: data shifted out on falling edges, host samples on rising
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_shift  <= 16'h0000;
            ser_sdo    <= 1'b0;
            ser_sdo_oe <= 1'b0;
        end else if (csb_sync) begin
            ser_sdo    <= 1'b0;
            ser_sdo_oe <= 1'b0;
        end else if (state == SDC_HEAD && sck_rise && bit_cnt == SDC_HEAD_LAST) begin
            out_shift <= head_rdata;
        end else if (state == SDC_BODY && frame_read && sck_fall) begin
            ser_sdo    <= out_shift[15];
            ser_sdo_oe <= 1'b1;
            out_shift  <= {out_shift[14:0], 1'b0};
        end
    end

    // Every word is stored whole, reserved bits too, so the host's defaults stick
    for (genvar i = 0; i < SDC_NUM_REGS; i++) begin : g_reg
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                regs[i] <= SDC_REG_RST[i];
            end else if (commit && frame_hit[i]) begin
                regs[i] <= next_data;
            end
        end
    end

    assign osc_doubler_enable        = regs[SDC_I_DBL_DITH][SDC_B_DOUBLER];
    assign modulator_dither          = regs[SDC_I_DBL_DITH][SDC_B_DITHER];
    assign osc_to_outb_buffer_off    = regs[SDC_I_DIST_PWR][SDC_B_OUTB_OFF];
    assign osc_to_outa_buffer_off    = regs[SDC_I_DIST_PWR][SDC_B_OUTA_OFF];
    assign divider_feed_buffer_off   = regs[SDC_I_DIST_PWR][SDC_B_FEED_OFF];
    assign chan_divider_on           = regs[SDC_I_CHAN_DIVIDER_ON][SDC_B_CHDIV_ON];
    assign second_segment_ratio      = regs[SDC_I_SEG_CTRL][SDC_F_SEG2_LSB +: 4];
    assign third_segment_on          = regs[SDC_I_SEG_CTRL][SDC_B_SEG3_ON];
    assign second_segment_on         = regs[SDC_I_SEG_CTRL][SDC_B_SEG2_ON];
    assign first_segment_on          = regs[SDC_I_SEG_CTRL][SDC_B_SEG1_ON];
    assign first_segment_ratio       = regs[SDC_I_SEG_CTRL][SDC_B_SEG1_RATIO];
    assign divider_to_outb_buffer_on = regs[SDC_I_DIV_OUT][SDC_B_DIV_OUTB_ON];
    assign divider_to_outa_buffer_on = regs[SDC_I_DIV_OUT][SDC_B_DIV_OUTA_ON];
    assign segment_chain_select      = regs[SDC_I_DIV_OUT][SDC_F_CHAIN_LSB +: 3];
    assign third_segment_ratio       = regs[SDC_I_DIV_OUT][SDC_F_SEG3_LSB +: 4];
    assign prescaler_by_four         = regs[SDC_I_PRESCALE][SDC_B_PRESCALE];
    assign feedback_integer_value    = regs[SDC_I_INTEGER][SDC_F_INT_LSB +: 12];
    assign phase_detector_delay_sel  = regs[SDC_I_PD_DELAY][SDC_F_PDD_LSB +: 6];
    assign fraction_denominator      = {regs[SDC_I_DEN_HIGH], regs[SDC_I_DEN_LOW]};
    assign modulator_order           = regs[SDC_I_MOD_ORDER][SDC_F_ORDER_LSB +: 3];
    assign reserved_cfg_a            = regs[0];
    assign reserved_cfg_b            = regs[1];
    assign reserved_cfg_c            = regs[2];
    assign reserved_cfg_d            = regs[5];
    assign reserved_cfg_e            = regs[6];

    // One-hot ratio code to divide value; any other code counts as off
    function automatic logic [3:0] seg_divide(input logic [3:0] code);
        case (code)
            4'h8:    seg_divide = 4'h8;
            4'h4:    seg_divide = 4'h6;
            4'h2:    seg_divide = 4'h4;
            4'h1:    seg_divide = 4'h2;
            default: seg_divide = 4'h0;
        endcase
    endfunction : seg_divide

    function automatic logic [4:0] pd_cycles(input logic [5:0] code);
        case (code)
            6'h01:   pd_cycles = 5'h04;
            6'h02:   pd_cycles = 5'h06;
            6'h04:   pd_cycles = 5'h08;
            6'h08:   pd_cycles = 5'h0c;
            6'h10:   pd_cycles = 5'h10;
            default: pd_cycles = 5'h00;
        endcase
    endfunction : pd_cycles

    // Decoded views are registered: one clock behind the raw fields
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            first_segment_divide        <= 2'h0;
            second_segment_divide       <= 4'h0;
            third_segment_divide        <= 4'h0;
            segments_in_chain           <= 2'h0;
            prescaler_divide            <= 3'h0;
            phase_detector_delay_cycles <= 5'h00;
            fractional_mode             <= 1'b0;
            modulator_dither_active     <= 1'b0;
        end else begin
            first_segment_divide  <= first_segment_ratio ? 2'h3 : 2'h2;
            second_segment_divide <= seg_divide(second_segment_ratio);
            third_segment_divide  <= seg_divide(third_segment_ratio);
            case (segment_chain_select)
                3'h4:    segments_in_chain <= 2'h3;
                3'h2:    segments_in_chain <= 2'h2;
                3'h1:    segments_in_chain <= 2'h1;
                default: segments_in_chain <= 2'h0;
            endcase
            prescaler_divide            <= prescaler_by_four ? 3'h4 : 3'h2;
            phase_detector_delay_cycles <= pd_cycles(phase_detector_delay_sel);
            fractional_mode             <= (modulator_order != 3'h0);
            // Dither has no meaning in integer mode, so it is held off there
            modulator_dither_active     <= modulator_dither && (modulator_order != 3'h0);
        end
    end

endmodule : sdc_config_regs

// >>> sdc_expect.svh
// Expected decodes of the one-hot ratio, chain and delay codes
function automatic logic [3:0] sdc_seg_div(input logic [3:0] c);
    return (c == 4'h8) ? 4'h8 : (c == 4'h4) ? 4'h6 : (c == 4'h2) ? 4'h4 : (c == 4'h1) ? 4'h2 : 4'h0;
endfunction : sdc_seg_div
function automatic logic [1:0] sdc_chain(input logic [2:0] c);
    return (c == 3'h4) ? 2'h3 : (c == 3'h2) ? 2'h2 : (c == 3'h1) ? 2'h1 : 2'h0;
endfunction : sdc_chain
function automatic logic [4:0] sdc_delay(input logic [5:0] c);
    return (c == 6'h01) ? 5'h04 : (c == 6'h02) ? 5'h06 : (c == 6'h04) ? 5'h08 :
           (c == 6'h08) ? 5'h0c : (c == 6'h10) ? 5'h10 : 5'h00;
endfunction : sdc_delay

// >>> sdc_config_regs_checker.sv
module sdc_config_regs_checker (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        ser_csb_n,
    input wire logic        ser_sdo,
    input wire logic        ser_sdo_oe,
    input wire logic        modulator_dither,
    input wire logic        modulator_dither_active,
    input wire logic        fractional_mode,
    input wire logic        first_segment_ratio,
    input wire logic        prescaler_by_four,
    input wire logic [1:0]  first_segment_divide,
    input wire logic [1:0]  segments_in_chain,
    input wire logic [2:0]  segment_chain_select,
    input wire logic [2:0]  prescaler_divide,
    input wire logic [2:0]  modulator_order,
    input wire logic [3:0]  second_segment_ratio,
    input wire logic [3:0]  third_segment_ratio,
    input wire logic [3:0]  second_segment_divide,
    input wire logic [3:0]  third_segment_divide,
    input wire logic [4:0]  phase_detector_delay_cycles,
    input wire logic [5:0]  phase_detector_delay_sel,
    input wire logic [31:0] fraction_denominator
);
    timeunit 1ns;
    timeprecision 1ps;
    `include "sdc_expect.svh"
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Decodes lag one edge, so the first edge after reset is skipped
    logic up;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) up <= 1'b0;
        else up <= 1'b1;
    end
    AST_SEG1_DIV: assert property (
        up |-> first_segment_divide == ($past(first_segment_ratio) ? 2'h3 : 2'h2))
        else $error("seg1 divide wrong");
    AST_SEG2_DIV: assert property (
        up && $changed(second_segment_ratio) |=> second_segment_divide == sdc_seg_div($past(second_segment_ratio)))
        else $error("second segment divide wrong");
    AST_SEG3_DIV: assert property (
        up |-> third_segment_divide == sdc_seg_div($past(third_segment_ratio)))
        else $error("third segment divide wrong");
    AST_CHAIN: assert property (
        up |-> segments_in_chain == sdc_chain($past(segment_chain_select)))
        else $error("chain length wrong");
    AST_PRESCALE: assert property (
        up ##1 $stable(prescaler_by_four) |-> prescaler_divide == (prescaler_by_four ? 3'h4 : 3'h2))
        else $error("prescaler divide wrong");
    AST_PD_DELAY: assert property (
        up |-> phase_detector_delay_cycles == sdc_delay($past(phase_detector_delay_sel)))
        else $error("delay cycles wrong");
    AST_FRAC: assert property (
        up && modulator_order == 3'h0 |=> !fractional_mode)
        else $error("integer mode not seen");
    AST_DITHER: assert property (
        up |-> modulator_dither_active == ($past(modulator_dither) && $past(modulator_order) != 3'h0))
        else $error("effective dither wrong");
    AST_IDLE: assert property (
        ser_csb_n [*5] |-> !ser_sdo_oe && !ser_sdo)
        else $error("sdo busy while idle");
    AST_HOLD: assert property (
        ser_csb_n [*6] |-> $stable(fraction_denominator) && $stable(modulator_order))
        else $error("change without frame");
    COV_READ: cover property (ser_sdo_oe);
    COV_CHAIN3: cover property (segments_in_chain == 2'h3);
    COV_DLY16: cover property (phase_detector_delay_cycles == 5'h10);
    COV_DITHER: cover property (modulator_dither_active);
endmodule : sdc_config_regs_checker

// >>> sdc_host_model.sv
module sdc_host_model (
    input  wire logic sys_clk,
    output logic      ser_csb_n,
    output logic      ser_sck,
    output logic      ser_sdi,
    input  wire logic ser_sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    import sdc_pkg::*;
    initial {ser_csb_n, ser_sck, ser_sdi} = 3'b100;
    // Clock stands low between frames; sdi flips once released
    task automatic frame(input logic rd, input sdc_addr_t a, input sdc_word_t d,
                         input int nbits, output sdc_word_t q);
        logic [23:0] f;
        f = {rd, a, d};
        q = '0;
        @(posedge sys_clk) ser_csb_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int i = 23; i >= 24 - nbits; i--) begin
            ser_sdi <= f[i];
            repeat (5) @(posedge sys_clk);
            ser_sck <= 1'b1;
            q = {q[14:0], ser_sdo};
            repeat (5) @(posedge sys_clk);
            ser_sck <= 1'b0;
        end
        repeat (2) @(posedge sys_clk);
        ser_csb_n <= 1'b1;
        ser_sdi <= ~ser_sdi;
        repeat (8) @(posedge sys_clk);
    endtask : frame
endmodule : sdc_host_model

// >>> sdc_config_regs_test.sv
module sdc_config_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sdc_pkg::*;
    `include "sdc_expect.svh"
    localparam logic [3:0] SEG_C [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h3};
    localparam logic [2:0] CHN_C [6] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h3, 3'h7};
    localparam logic [5:0] DLY_C [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    logic sys_clk, arst_n, ser_csb_n, ser_sck, ser_sdi, ser_sdo, ser_sdo_oe;
    logic osc_doubler_enable, modulator_dither, modulator_dither_active, osc_to_outb_buffer_off;
    logic osc_to_outa_buffer_off, divider_feed_buffer_off, chan_divider_on, first_segment_on;
    logic second_segment_on, third_segment_on, first_segment_ratio, divider_to_outb_buffer_on;
    logic divider_to_outa_buffer_on, prescaler_by_four, fractional_mode;
    logic [1:0] first_segment_divide, segments_in_chain;
    logic [2:0] segment_chain_select, prescaler_divide, modulator_order;
    logic [3:0] second_segment_ratio, third_segment_ratio, second_segment_divide, third_segment_divide;
    logic [4:0] phase_detector_delay_cycles;
    logic [5:0] phase_detector_delay_sel;
    logic [11:0] feedback_integer_value;
    logic [31:0] fraction_denominator;
    sdc_word_t reserved_cfg_a, reserved_cfg_b, reserved_cfg_c, reserved_cfg_d, reserved_cfg_e;
    sdc_word_t mem [128];
    sdc_word_t q, d;
    int error_cnt, samples_checked, seed;
    sdc_config_regs sdc_config_regs_inst (.*);
    sdc_host_model sdc_host_model_inst (.*);
    always #25 sys_clk = ~sys_clk;
    task automatic check(input logic [95:0] seen, input logic [95:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    // Unmapped offsets stay zero, as they read back
    task automatic rst_mem();
        foreach (mem[i]) mem[i] = 16'h0000;
        foreach (SDC_REG_ADDR[i]) mem[SDC_REG_ADDR[i]] = SDC_REG_RST[i];
    endtask : rst_mem
    task automatic wr(input sdc_addr_t a, input sdc_word_t v);
        sdc_host_model_inst.frame(1'b0, a, v, 24, q);
        if (a inside {SDC_REG_ADDR}) mem[a] = v;
    endtask : wr
    task automatic rd_all();
        for (int a = 8'h18; a < 8'h30; a++) begin
            sdc_host_model_inst.frame(1'b1, 7'(a), 16'h0000, 24, q);
            check(q, mem[a], "readback");
        end
    endtask : rd_all
    task automatic chk_ports();
        check({osc_doubler_enable, modulator_dither, osc_to_outb_buffer_off, osc_to_outa_buffer_off,
               divider_feed_buffer_off, chan_divider_on, second_segment_ratio, third_segment_on,
               second_segment_on, first_segment_ratio, first_segment_on, divider_to_outb_buffer_on,
               divider_to_outa_buffer_on, segment_chain_select, third_segment_ratio,
               prescaler_by_four, feedback_integer_value, phase_detector_delay_sel, modulator_order},
              {mem[7'h1e][0], mem[7'h1e][10], mem[7'h1f][10], mem[7'h1f][9], mem[7'h1f][7],
               mem[7'h22][5], mem[7'h23][12:9], mem[7'h23][8], mem[7'h23][7], mem[7'h23][2],
               mem[7'h23][1], mem[7'h24][11], mem[7'h24][10], mem[7'h24][6:4], mem[7'h24][3:0],
               mem[7'h25][12], mem[7'h26][12:1], mem[7'h27][13:8], mem[7'h2e][2:0]},
              "fields");
        check(fraction_denominator, {mem[7'h28], mem[7'h29]}, "denominator");
        check({reserved_cfg_a, reserved_cfg_b, reserved_cfg_c, reserved_cfg_d, reserved_cfg_e},
              {mem[7'h19], mem[7'h1c], mem[7'h1d], mem[7'h20], mem[7'h21]}, "reserved");
    endtask : chk_ports
    task automatic chk_dec();
        check({first_segment_divide, second_segment_divide, third_segment_divide, segments_in_chain,
               prescaler_divide, phase_detector_delay_cycles, fractional_mode, modulator_dither_active},
              {(mem[7'h23][2] ? 2'h3 : 2'h2), sdc_seg_div(mem[7'h23][12:9]),
               sdc_seg_div(mem[7'h24][3:0]), sdc_chain(mem[7'h24][6:4]),
               (mem[7'h25][12] ? 3'h4 : 3'h2), sdc_delay(mem[7'h27][13:8]), mem[7'h2e][2:0] != 3'h0,
               mem[7'h1e][10] && mem[7'h2e][2:0] != 3'h0}, "decode");
    endtask : chk_dec
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        sys_clk = 1'b0;
        arst_n = 1'b0;
        seed = 77;
        error_cnt = 0;
        samples_checked = 0;
        rst_mem();
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk_ports();
        chk_dec();
        rd_all();
        $display("test reset values done");
        foreach (SDC_REG_ADDR[i]) begin
            d = sdc_word_t'($random(seed));
            if (i inside {[0:2], 5, 6}) d = 16'h0000;
            wr(SDC_REG_ADDR[i], d);
            chk_ports();
        end
        chk_dec();
        rd_all();
        $display("test random writes done");
        wr(7'h1e, 16'h0400);
        for (int i = 0; i < 6; i++) begin
            wr(7'h23, {3'h0, SEG_C[i], 6'h00, i[0], 2'h0});
            wr(7'h24, {9'h000, CHN_C[i], SEG_C[i]});
            wr(7'h27, {2'h0, DLY_C[i], 8'h00});
            wr(7'h25, {3'h0, i[1], 12'h000});
            wr(7'h2e, {13'h01f0, 3'(i)});
            chk_ports();
            chk_dec();
        end
        $display("test code tables done");
        wr(7'h2a, 16'h5a5a);
        wr(7'h00, 16'ha5a5);
        // Frame cut short after 20 bits must leave the register alone
        sdc_host_model_inst.frame(1'b0, 7'h26, 16'h1234, 20, q);
        chk_ports();
        rd_all();
        $display("test unmapped and aborted done");
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        rst_mem();
        repeat (3) @(posedge sys_clk);
        chk_ports();
        chk_dec();
        rd_all();
        $display("test second reset done");
        end_sim();
    end
endmodule : sdc_config_regs_test
bind sdc_config_regs sdc_config_regs_checker sdc_config_regs_checker_inst (.*);
